// ### core/wdg_chain.sv
// Prescaler and counter chain with timeout compare
`timescale 1ns/1ps
module wdg_chain
  import wdg_pkg::*;
#(
  parameter int PRE_W = WDG_PRE_W,
  parameter int CNT_W = WDG_CNT_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Chain control
  wdg_chain_if.chain bus
);

  if (PRE_W != WDG_PRE_W || CNT_W != WDG_CNT_W || PRE_W <= WDG_SVC_LO_BIT) begin : g_chk
    $error("wdg_chain: widths must match the chain interface");
  end

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [PRE_W-1:0] pre;
  } wdg_chain_s;

  wdg_chain_s       st_reg;
  wdg_chain_s       st_next;
  logic [17:0]      limit;

  assign limit      = bus.rate_sel ? WDG_TIMEOUT_LONG : WDG_TIMEOUT_SHORT;
  // Counter steps on prescaler rollover; compare on the joined value
  assign bus.expire = bus.tick && (st_reg == wdg_chain_s'(limit - 18'h00001));
  assign bus.pre    = st_reg.pre;
  assign bus.cnt    = st_reg.cnt;

  always_comb begin
    st_next = st_reg;
    if (bus.tick) begin
      st_next = st_reg + wdg_chain_s'(1);
    end
    if (bus.clr_upper) begin
      st_next.cnt = '0;
      st_next.pre[PRE_W-1:WDG_SVC_LO_BIT] = '0;
    end
    if (bus.clr_pre) begin
      st_next.pre = '0;
    end
    // Expiry restarts the period so a held reset cannot retrigger early
    if (bus.clr_all || bus.expire) begin
      st_next = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule : wdg_chain

// ### core/wdg_pulse.sv
// Stretches a watchdog expiry into a reset pin pulse of fixed ticks
`timescale 1ns/1ps
module wdg_pulse
  import wdg_pkg::*;
(
  // Clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // Trigger and tick
  input  wire logic start,
  input  wire logic tick_en,
  // Pulse out
  output logic      active
);

  typedef struct packed {
    logic                   active;
    logic [WDG_PULSE_W-1:0] cnt;
  } wdg_pulse_s;

  wdg_pulse_s st_reg;
  wdg_pulse_s st_next;

  assign active = st_reg.active;

  always_comb begin
    st_next = st_reg;
    if (!st_reg.active) begin
      if (start) begin
        st_next.active = 1'b1;
        st_next.cnt    = '0;
      end
    end else if (tick_en) begin
      if (st_reg.cnt == WDG_PULSE_LAST) begin
        st_next.active = 1'b0;
      end else begin
        st_next.cnt = st_reg.cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  property p_pulse_len;
    @(posedge clk) disable iff (!reset_n)
      $fell(st_reg.active) |-> $past(st_reg.cnt) == WDG_PULSE_LAST && $past(tick_en);
  endproperty
  a_pulse_len: assert property (p_pulse_len)
    else $error("reset pulse ended before its full tick count");

endmodule : wdg_pulse

// ### core/wdg_top.sv
// Watchdog counter service: control, disables, service register, reset output
//
// Contract
// - Stop instruction clears the prescaler.
// - Service write zeroes counter and prescaler stages 12-5.
// - Service read returns reset vector low byte.
// - Prescaler cleared 4096 crystal cycles after power-up.
// - Internal reset clears prescaler and counter.
// - Reset vector fetch clears the prescaler.
// - Disable input follows its configuration bit.
// - Length select follows its configuration bit.
// - Service register at top address starts new period.
// - Never raises an interrupt; expiry only resets.
// - Test-voltage monitor entry disables while voltage stays.
// - Blank-vector monitor entry disables until power-on.
// - Keeps counting in wait mode.
// - Stop mode gates tick, clears prescaler.
// - Disabled stop instruction gives illegal opcode reset.
// - Break with test voltage on reset disables.
// - 6-bit counter, 12-bit prescaler, two timeout lengths.
// - Expiry drives reset low 32 ticks, sets flag.
// - Disable bit one stops, zero runs.
`timescale 1ns/1ps
module wdg_top
  import wdg_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Clock enables
  input  wire logic        tick_en,
  input  wire logic        xtal_en,
  // Internal bus
  input  wire logic [15:0] addr,
  input  wire logic        wr_en,
  input  wire logic        rd_en,
  input  wire logic [7:0]  wdata,
  output logic      [7:0]  rdata,
  input  wire logic [7:0]  vec_low,
  // Core events and modes
  input  wire logic        vector_fetch,
  input  wire logic        stop_exec,
  input  wire logic        stop_mode,
  input  wire logic        wait_mode,
  input  wire logic        int_reset,
  // Configuration bits
  input  wire logic        watchdog_disable,
  input  wire logic        timeout_length_select,
  input  wire logic        stop_enable,
  // Monitor and break
  input  wire logic        monitor_entry,
  input  wire logic        blank_vectors,
  input  wire logic        test_entry_voltage_irq,
  input  wire logic        test_entry_voltage_rst,
  input  wire logic        break_active,
  // Reset pin, open drain
  input  wire logic        rst_pin_i,
  output logic             rst_pin_o,
  output logic             rst_pin_oe,
  // Reset sources and stop entry
  output logic             wdg_reset_flag,
  output logic             illegal_opcode_reset,
  output logic             stop_entry
);

  // ********************************************************
  // State
  // ********************************************************
  typedef struct packed {
    logic [7:0]           rdata;
    logic                 mon_test_entry_voltage;
    logic                 mon_blank;
    logic [WDG_POR_W-1:0] por_cnt;
    logic                 por_done;
    logic                 flag;
    logic                 ill;
    logic                 stop_go;
  } wdg_top_s;

  wdg_top_s    st_reg;
  wdg_top_s    st_next;

  wdg_chain_if ch();

  logic        svc_hit;
  logic        svc_wr;
  logic        svc_rd;
  logic        stop_ok;
  logic        por_clr;
  logic        dis;
  logic        pulse_on;

  // ********************************************************
  // Decode and disables
  // ********************************************************
  assign svc_hit = (addr == WDG_SERVICE_ADDR);
  assign svc_wr  = wr_en && svc_hit;
  assign svc_rd  = rd_en && svc_hit;
  assign stop_ok = stop_exec && stop_enable;
  assign por_clr = !st_reg.por_done && xtal_en && (st_reg.por_cnt == WDG_POR_LAST);

  // Config bits are sampled live, never latched
  assign dis = watchdog_disable
             || st_reg.mon_test_entry_voltage
             || st_reg.mon_blank
             || (break_active && test_entry_voltage_rst);

  // ********************************************************
  // Chain control
  // ********************************************************
  // Wait mode deliberately not in the gate
  assign ch.tick      = tick_en && !stop_mode && !dis;
  assign ch.clr_all   = int_reset;
  assign ch.clr_pre   = stop_ok || stop_mode || vector_fetch || por_clr;
  assign ch.clr_upper = svc_wr;
  assign ch.rate_sel  = timeout_length_select;

  wdg_chain u_chain (
    .clk     (clk),
    .reset_n (reset_n),
    .bus     (ch.chain)
  );

  wdg_pulse u_pulse (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (ch.expire),
    .tick_en (tick_en),
    .active  (pulse_on)
  );

  // ********************************************************
  // Outputs
  // ********************************************************
  // No interrupt output exists; expiry only pulls the reset pin
  assign rst_pin_o            = 1'b0;
  assign rst_pin_oe           = pulse_on;
  assign rdata                = st_reg.rdata;
  assign wdg_reset_flag       = st_reg.flag;
  assign illegal_opcode_reset = st_reg.ill;
  assign stop_entry           = st_reg.stop_go;

  // ********************************************************
  // Next state
  // ********************************************************
  always_comb begin
    st_next         = st_reg;
    st_next.flag    = ch.expire;
    st_next.ill     = stop_exec && !stop_enable;
    st_next.stop_go = stop_ok;
    if (svc_rd) begin
      st_next.rdata = vec_low;
    end
    if (!st_reg.por_done && xtal_en) begin
      st_next.por_cnt = st_reg.por_cnt + 12'h001;
      if (por_clr) begin
        st_next.por_done = 1'b1;
      end
    end
    // Hold only while the test voltage persists on either pin
    if (monitor_entry && test_entry_voltage_irq) begin
      st_next.mon_test_entry_voltage = 1'b1;
    end else if (!test_entry_voltage_irq && !test_entry_voltage_rst) begin
      st_next.mon_test_entry_voltage = 1'b0;
    end
    // Only power-on reset releases this one
    if (monitor_entry && blank_vectors && !test_entry_voltage_irq) begin
      st_next.mon_blank = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ********************************************************
  // Checks
  // ********************************************************
  property p_stop_clr;
    @(posedge clk) disable iff (!reset_n)
      stop_ok |=> ch.pre == '0 && stop_entry && !illegal_opcode_reset;
  endproperty
  a_stop_clr: assert property (p_stop_clr)
    else $error("stop instruction did not clear prescaler");

  property p_service;
    @(posedge clk) disable iff (!reset_n)
      svc_wr && !ch.tick && !ch.clr_pre && !int_reset
      |=> ch.cnt == '0 && ch.pre[WDG_PRE_W-1:WDG_SVC_LO_BIT] == '0
          && ch.pre[WDG_SVC_LO_BIT-1:0] == $past(ch.pre[WDG_SVC_LO_BIT-1:0]);
  endproperty
  a_service: assert property (p_service)
    else $error("service write did not clear the right stages");

  property p_read;
    @(posedge clk) disable iff (!reset_n)
      svc_rd && !wr_en && !ch.tick && !int_reset && !ch.clr_pre
      |=> rdata == $past(vec_low) && ch.cnt == $past(ch.cnt) && ch.pre == $past(ch.pre);
  endproperty
  a_read: assert property (p_read)
    else $error("service read wrong data or disturbed count");

  property p_por;
    @(posedge clk) disable iff (!reset_n)
      por_clr |=> st_reg.por_done && ch.pre == '0 ##1 st_reg.por_done;
  endproperty
  a_por: assert property (p_por)
    else $error("power-up prescaler clear missing");

  property p_int_reset;
    @(posedge clk) disable iff (!reset_n)
      int_reset |=> ch.cnt == '0 && ch.pre == '0;
  endproperty
  a_int_reset: assert property (p_int_reset)
    else $error("internal reset did not clear chain");

  property p_vec_fetch;
    @(posedge clk) disable iff (!reset_n)
      vector_fetch |=> ch.pre == '0;
  endproperty
  a_vec_fetch: assert property (p_vec_fetch)
    else $error("vector fetch did not clear prescaler");

  property p_disabled;
    @(posedge clk) disable iff (!reset_n)
      watchdog_disable || st_reg.mon_test_entry_voltage || st_reg.mon_blank || (break_active && test_entry_voltage_rst)
      |-> !ch.tick && !ch.expire;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("chain advanced while disabled");

  property p_mon_blank;
    @(posedge clk) disable iff (!reset_n)
      st_reg.mon_blank |=> st_reg.mon_blank;
  endproperty
  a_mon_blank: assert property (p_mon_blank)
    else $error("blank-vector monitor disable released early");

  property p_mon_test_entry_voltage;
    @(posedge clk) disable iff (!reset_n)
      monitor_entry && test_entry_voltage_irq ##1 (test_entry_voltage_irq || test_entry_voltage_rst) |-> st_reg.mon_test_entry_voltage && !ch.tick;
  endproperty
  a_mon_test_entry_voltage: assert property (p_mon_test_entry_voltage)
    else $error("test-voltage monitor disable not held");

  property p_wait_runs;
    @(posedge clk) disable iff (!reset_n)
      wait_mode && tick_en && !stop_mode && !dis |-> ch.tick;
  endproperty
  a_wait_runs: assert property (p_wait_runs)
    else $error("counting stopped in wait mode");

  property p_stop_mode;
    @(posedge clk) disable iff (!reset_n)
      stop_mode && !int_reset && !svc_wr |=> ch.pre == '0 && ch.cnt == $past(ch.cnt);
  endproperty
  a_stop_mode: assert property (p_stop_mode)
    else $error("chain moved during stop mode");

  property p_illegal;
    @(posedge clk) disable iff (!reset_n)
      stop_exec && !stop_enable |=> illegal_opcode_reset && !stop_entry;
  endproperty
  a_illegal: assert property (p_illegal)
    else $error("disabled stop did not raise illegal opcode reset");

  property p_expire_pt;
    @(posedge clk) disable iff (!reset_n)
      ch.expire |-> {ch.cnt, ch.pre} ==
        (timeout_length_select ? WDG_TIMEOUT_LONG : WDG_TIMEOUT_SHORT) - 18'h00001;
  endproperty
  a_expire_pt: assert property (p_expire_pt)
    else $error("expiry at wrong count");

  property p_expire_out;
    @(posedge clk) disable iff (!reset_n)
      ch.expire && !rst_pin_oe |=> rst_pin_oe && wdg_reset_flag && !rst_pin_o;
  endproperty
  a_expire_out: assert property (p_expire_out)
    else $error("expiry did not pull reset pin and set flag");

  c_expire:  cover property (@(posedge clk) disable iff (!reset_n) ch.expire);
  c_service: cover property (@(posedge clk) disable iff (!reset_n) svc_wr && ch.cnt != '0);
  c_blank:   cover property (@(posedge clk) disable iff (!reset_n) st_reg.mon_blank);
  c_pin:     cover property (@(posedge clk) disable iff (!reset_n) rst_pin_oe && !rst_pin_i);

endmodule : wdg_top

// ### shared/wdg_chain_if.sv
// Control and status of the prescaler/counter chain
`timescale 1ns/1ps
interface wdg_chain_if;
  import wdg_pkg::*;
  logic                 tick;
  logic                 clr_all;
  logic                 clr_pre;
  logic                 clr_upper;
  logic                 rate_sel;
  logic [WDG_PRE_W-1:0] pre;
  logic [WDG_CNT_W-1:0] cnt;
  logic                 expire;

  modport chain (input tick, clr_all, clr_pre, clr_upper, rate_sel,
                 output pre, cnt, expire);
  modport ctrl  (output tick, clr_all, clr_pre, clr_upper, rate_sel,
                 input pre, cnt, expire);
endinterface : wdg_chain_if

// ### shared/wdg_pkg.sv
// Constants shared by the watchdog counter service blocks
package wdg_pkg;

  // ********************************************************
  // Register map
  // ********************************************************
  localparam logic [15:0] WDG_SERVICE_ADDR  = 16'hFFFF;

  // ********************************************************
  // Counter chain layout
  // ********************************************************
  localparam int          WDG_PRE_W         = 12;
  localparam int          WDG_CNT_W         = 6;
  localparam int          WDG_CHAIN_W       = WDG_PRE_W + WDG_CNT_W;
  // Service clears prescaler stages 12..5, i.e. bit 4 upward
  localparam int          WDG_SVC_LO_BIT    = 4;

  // ********************************************************
  // Timing, in tick clock cycles
  // ********************************************************
  localparam logic [17:0] WDG_TIMEOUT_LONG  = 18'h3FFF0;
  localparam logic [17:0] WDG_TIMEOUT_SHORT = 18'h01FF0;
  localparam int          WDG_PULSE_W       = 5;
  localparam logic [4:0]  WDG_PULSE_LAST    = 5'h1F;

  // ********************************************************
  // Power-up delay, in crystal reference cycles
  // ********************************************************
  localparam int          WDG_POR_W         = 12;
  localparam logic [11:0] WDG_POR_LAST      = 12'hFFF;

endpackage : wdg_pkg

// ### sim/wdg_cpu_model.sv
// CPU core model driving the internal bus toward the watchdog
`timescale 1ns/1ps
module wdg_cpu_model (
  // Clock
  input  wire logic        clk,
  // Internal bus
  output logic      [15:0] addr,
  output logic             wr_en,
  output logic             rd_en,
  output logic      [7:0]  wdata,
  output logic      [7:0]  vec_low
);
  initial begin
    addr = 16'h0000;
    wr_en = 1'b0;
    rd_en = 1'b0;
    wdata = 8'h00;
    vec_low = 8'h00;
  end

  // ********************************************************
  // One byte cycle
  // ********************************************************
  task automatic bus_op(input logic wr, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_en <= wr;
    rd_en <= !wr;
    wdata <= d;
    vec_low <= d;
    @(posedge clk);
    addr <= ~a;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    // Released lines change so a stale byte cannot pass
    wdata <= ~d;
    vec_low <= ~d;
  endtask : bus_op
endmodule : wdg_cpu_model

// ### sim/wdg_top_bench.sv
// Self-checking bench for the watchdog counter service block
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[ERR] t=%0t act=%0h exp=%0h", $time, (a), (e)); end end
module wdg_top_bench;
  import wdg_pkg::*;
  typedef struct {logic [2:0] kind; int lo; int hi;} wdg_note_s;
  localparam int SPAN = int'(WDG_TIMEOUT_SHORT);
  logic        clk, reset_n, tick_en, xtal_en, vector_fetch, stop_exec, stop_mode;
  logic        wait_mode, int_reset, watchdog_disable, timeout_length_select;
  logic        stop_enable, monitor_entry, blank_vectors, test_entry_voltage_irq, test_entry_voltage_rst;
  logic        break_active, wr_en, rd_en, rst_pin_o, rst_pin_oe, wdg_reset_flag;
  logic        illegal_opcode_reset, stop_entry, rd_seen;
  logic [15:0] addr, a;
  logic [7:0]  wdata, vec_low, rdata, v;
  wire         rst_pin = rst_pin_oe ? rst_pin_o : 1'b1;
  int          num_checks, n_mismatch, cyc, oe_cnt;
  wdg_note_s   q[$];
  wdg_note_s   n_mon;

  wdg_cpu_model u_cpu (.clk(clk), .addr(addr), .wr_en(wr_en), .rd_en(rd_en),
    .wdata(wdata), .vec_low(vec_low));

  wdg_top u_dut (.clk(clk), .reset_n(reset_n), .tick_en(tick_en), .xtal_en(xtal_en),
    .addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata), .rdata(rdata),
    .vec_low(vec_low), .vector_fetch(vector_fetch), .stop_exec(stop_exec),
    .stop_mode(stop_mode), .wait_mode(wait_mode), .int_reset(int_reset),
    .watchdog_disable(watchdog_disable), .timeout_length_select(timeout_length_select),
    .stop_enable(stop_enable), .monitor_entry(monitor_entry),
    .blank_vectors(blank_vectors), .test_entry_voltage_irq(test_entry_voltage_irq), .test_entry_voltage_rst(test_entry_voltage_rst),
    .break_active(break_active), .rst_pin_i(rst_pin), .rst_pin_o(rst_pin_o),
    .rst_pin_oe(rst_pin_oe), .wdg_reset_flag(wdg_reset_flag),
    .illegal_opcode_reset(illegal_opcode_reset), .stop_entry(stop_entry));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ********************************************************
  // Output watcher
  // ********************************************************
  task automatic take(input logic [2:0] k);
    n_mon = '{3'h7, 0, -1};
    if (q.size() != 0) n_mon = q.pop_front();
    `CHK(n_mon.kind, k)
  endtask : take

  // Outputs are unknown until the first reset edge, so watch only out of reset
  always @(posedge clk) begin
    cyc <= cyc + 1;
    rd_seen <= rd_en;
    if (reset_n === 1'b1) begin
      if (rd_seen) begin
        take(3'h0);
        `CHK(rdata, n_mon.lo[7:0])
      end
      if (wdg_reset_flag !== 1'b0) begin
        take(3'h1);
        `CHK((cyc >= n_mon.lo && cyc <= n_mon.hi), 1'b1)
      end
      if (rst_pin_oe === 1'b1) begin
        oe_cnt <= oe_cnt + 1;
      end else if (oe_cnt != 0) begin
        `CHK(oe_cnt, 32)
        oe_cnt <= 0;
      end
      if (stop_entry !== 1'b0) take(3'h2);
      if (illegal_opcode_reset !== 1'b0) take(3'h3);
    end
  end

  // ********************************************************
  // Stimulus helpers
  // ********************************************************
  task automatic svc();
    u_cpu.bus_op(1'b1, WDG_SERVICE_ADDR, 8'($urandom));
  endtask : svc

  task automatic expect_exp();
    q.push_back('{3'h1, cyc + SPAN - 18, cyc + SPAN + 4});
  endtask : expect_exp

  task automatic drain(input string name);
    int k;
    k = 0;
    while (q.size() != 0 && k < 9000) begin
      @(posedge clk);
      k++;
    end
    if (q.size() != 0) begin
      n_mismatch++;
      q.delete();
    end
    $display("test %s done", name);
  endtask : drain

  // Each case must keep the chain from expiring past a full short period
  task automatic hold_case(input int i);
    svc();
    case (i)
      0: watchdog_disable <= 1'b1;
      1: timeout_length_select <= 1'b1;
      2: stop_mode <= 1'b1;
      3: vector_fetch <= 1'b1;
      4: {test_entry_voltage_irq, test_entry_voltage_rst, monitor_entry} <= 3'h7;
      5: {break_active, test_entry_voltage_rst} <= 2'h3;
      default: {blank_vectors, monitor_entry} <= 2'h3;
    endcase
    @(posedge clk);
    {test_entry_voltage_irq, monitor_entry, blank_vectors} <= 3'h0;
    repeat (8190) @(posedge clk);
    {watchdog_disable, timeout_length_select, stop_mode} <= 3'h0;
    {vector_fetch, test_entry_voltage_rst, break_active} <= 3'h0;
    @(posedge clk);
    $display("test hold %0d done", i);
  endtask : hold_case

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    #9_500_000;
    n_mismatch++;
    wrap_up();
  end

  // ********************************************************
  // Main sequence
  // ********************************************************
  initial begin
    {reset_n, vector_fetch, stop_exec, stop_mode, wait_mode, int_reset} = 6'h00;
    {watchdog_disable, timeout_length_select, monitor_entry} = 3'h0;
    {blank_vectors, test_entry_voltage_irq, test_entry_voltage_rst, break_active, rd_seen} = 5'h00;
    {tick_en, xtal_en, stop_enable} = 3'h7;
    num_checks = 0;
    n_mismatch = 0;
    cyc = 0;
    oe_cnt = 0;
    void'($urandom(32'h9348));
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom);
      a = 16'($urandom_range(16'hFFFE));
      q.push_back('{3'h0, int'(v), 0});
      u_cpu.bus_op(1'b0, WDG_SERVICE_ADDR, v);
      q.push_back('{3'h0, int'(v), 0});
      u_cpu.bus_op(1'b0, a, ~v);
      u_cpu.bus_op(1'b1, a, v);
    end
    drain("read");
    for (int i = 0; i < 2; i++) begin
      stop_enable <= (i == 0);
      stop_exec <= 1'b1;
      q.push_back('{3'(2 + i), 0, 0});
      @(posedge clk);
      stop_exec <= 1'b0;
      @(posedge clk);
    end
    drain("stop");
    wait_mode <= 1'b1;
    svc();
    // Power-up prescaler clear must pass before the timed period starts
    repeat (4200) @(posedge clk);
    svc();
    expect_exp();
    drain("wait_timeout");
    wait_mode <= 1'b0;
    svc();
    repeat (3000) @(posedge clk);
    int_reset <= 1'b1;
    @(posedge clk);
    int_reset <= 1'b0;
    expect_exp();
    drain("int_reset");
    for (int i = 0; i < 7; i++) hold_case(i);
    reset_n <= 1'b0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    expect_exp();
    drain("power_on");
    wrap_up();
  end
endmodule : wdg_top_bench
